// [src/arb_guard_pkg.sv]
// Constants and types shared by the request guard of the secondary arbiter.
`default_nettype none
package arb_guard_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int REG_W = 8;
    localparam logic [7:0] REQ_IGNORE_OFFSET = 8'hdd;
    localparam logic [7:0] TIMED_OUT_OFFSET = 8'hde;
    localparam logic [7:0] REQ_IGNORE_RESET = 8'h00;
    localparam logic [7:0] TIMED_OUT_RESET = 8'h00;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TIMEOUT_ENABLE_BIT = 7;
    localparam int AUTO_IGNORE_BIT = 6;
    localparam int RESERVED_MSB = 7;
    localparam int RESERVED_LSB = 6;
    localparam int MAX_REQ = 6;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int TIMEOUT_CLOCKS = 16;
    localparam int CNT_W = 5;
    // ------------------------------------------------------------
    // Watch states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WATCH = 2'b00,
        COUNT = 2'b01,
        EXPIRED = 2'b11
    } watch_e;
endpackage : arb_guard_pkg
`default_nettype wire

// [src/arb_request_guard.sv]
// Request masking and grant time-out supervision for the secondary bus arbiter.
`timescale 1ns/1ps
`default_nettype none

module arb_request_guard #(
    parameter int NUM_REQ = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_reset,
    input wire logic global_reset_input,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic [arb_guard_pkg::REG_W-1:0] cfg_wdata,
    output logic [arb_guard_pkg::REG_W-1:0] cfg_rdata,
    input wire logic pci_clk,
    input wire logic pci_rst,
    input wire logic [NUM_REQ-1:0] req_n,
    input wire logic [NUM_REQ-1:0] grant,
    input wire logic frame_n,
    input wire logic irdy_n,
    output logic [NUM_REQ-1:0] req_to_arbiter
);
    import arb_guard_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (NUM_REQ < 1 || NUM_REQ > MAX_REQ) begin : g_bad_num_req
        $error("NUM_REQ must lie between 1 and 6");
    end

    // ------------------------------------------------------------
    // Register side, clk domain
    // ------------------------------------------------------------
    logic reg_rst;
    logic wr_ignore;
    logic wr_status;
    logic [REG_W-1:0] ignore_q;
    logic [REG_W-1:0] ignore_d;
    logic [NUM_REQ-1:0] status_q;
    logic [NUM_REQ-1:0] status_d;
    logic [NUM_REQ-1:0] event_clk;
    logic [REG_W-1:0] event_wide;

    assign reg_rst = rst | link_reset | global_reset_input;
    assign wr_ignore = cfg_wr && (cfg_addr == REQ_IGNORE_OFFSET);
    assign wr_status = cfg_wr && (cfg_addr == TIMED_OUT_OFFSET);
    assign event_wide = REG_W'(event_clk);

    always_comb begin
        ignore_d = wr_ignore ? cfg_wdata : ignore_q;
        if (ignore_q[AUTO_IGNORE_BIT]) begin
            // Hardware masking wins over a write in the same cycle.
            ignore_d = ignore_d | event_wide;
        end
    end

    always_ff @(posedge clk) begin
        if (reg_rst) begin
            ignore_q <= REQ_IGNORE_RESET;
        end else begin
            ignore_q <= ignore_d;
        end
    end

    always_comb begin
        status_d = status_q;
        if (wr_status) begin
            status_d = status_q & ~cfg_wdata[NUM_REQ-1:0];
        end
        status_d = status_d | event_clk;
    end

    always_ff @(posedge clk) begin
        if (reg_rst) begin
            status_q <= TIMED_OUT_RESET[NUM_REQ-1:0];
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reg_rst) begin
            cfg_rdata <= '0;
        end else begin
            case (cfg_addr)
                REQ_IGNORE_OFFSET: begin
                    cfg_rdata <= ignore_q;
                end
                TIMED_OUT_OFFSET: begin
                    // Upper bits are zero-filled, so reserved bits read 0.
                    cfg_rdata <= REG_W'(status_q);
                end
                default: begin
                    cfg_rdata <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control bits into the PCI clock domain
    // ------------------------------------------------------------
    // The bits are independent levels, so per-bit settling is safe.
    logic [REG_W-1:0] ctl_s1_q;
    logic [REG_W-1:0] ctl_s2_q;
    logic [REG_W-1:0] ctl_s3_q;
    logic [REG_W-1:0] ctl_q;
    logic [REG_W-1:0] ctl_agree;

    assign ctl_agree = ~(ctl_s2_q ^ ctl_s3_q);

    always_ff @(posedge pci_clk) begin
        if (pci_rst) begin
            ctl_s1_q <= REQ_IGNORE_RESET;
            ctl_s2_q <= REQ_IGNORE_RESET;
            ctl_s3_q <= REQ_IGNORE_RESET;
            ctl_q <= REQ_IGNORE_RESET;
        end else begin
            ctl_s1_q <= ignore_q;
            ctl_s2_q <= ctl_s1_q;
            ctl_s3_q <= ctl_s2_q;
            ctl_q <= (ctl_q & ~ctl_agree) | (ctl_s2_q & ctl_agree);
        end
    end

    // ------------------------------------------------------------
    // Grant watch, PCI clock domain
    // ------------------------------------------------------------
    watch_e state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [NUM_REQ-1:0] grant_q;
    logic [NUM_REQ-1:0] fire;
    logic idle;
    logic grant_moved;
    logic enabled;

    assign idle = frame_n & irdy_n;
    assign grant_moved = (grant != grant_q) || (grant == '0);
    assign enabled = ctl_q[TIMEOUT_ENABLE_BIT];
    assign fire = (state_q == COUNT && idle && !grant_moved && enabled
                   && cnt_q == CNT_W'(TIMEOUT_CLOCKS - 1)) ? grant_q : '0;

    always_ff @(posedge pci_clk) begin
        if (pci_rst) begin
            grant_q <= '0;
        end else begin
            grant_q <= grant;
        end
    end

    always_ff @(posedge pci_clk) begin
        if (pci_rst) begin
            state_q <= WATCH;
            cnt_q <= '0;
        end else begin
            case (state_q)
                WATCH: begin
                    cnt_q <= '0;
                    if (enabled && !grant_moved && idle) begin
                        state_q <= COUNT;
                        cnt_q <= CNT_W'(1);
                    end
                end
                COUNT: begin
                    if (!enabled || grant_moved || !frame_n) begin
                        state_q <= WATCH;
                        cnt_q <= '0;
                    end else if (|fire) begin
                        state_q <= EXPIRED;
                    end else if (idle) begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                EXPIRED: begin
                    // One report per grant; wait for the arbiter to move on.
                    if (grant_moved || !enabled) begin
                        state_q <= WATCH;
                        cnt_q <= '0;
                    end
                end
                default: begin
                    state_q <= WATCH;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Per-request masking and event crossing
    // ------------------------------------------------------------
    logic [NUM_REQ-1:0] local_q;
    logic [NUM_REQ-1:0] tog_q;

    // Local masking covers the gap until the register copy catches up.
    // It is dropped when auto masking goes off, so it never outlives the register.
    always_ff @(posedge pci_clk) begin
        if (pci_rst) begin
            local_q <= '0;
        end else begin
            local_q <= (local_q & ~ctl_q[NUM_REQ-1:0] & {NUM_REQ{ctl_q[AUTO_IGNORE_BIT]}})
                       | (ctl_q[AUTO_IGNORE_BIT] ? fire : '0);
        end
    end

    always_ff @(posedge pci_clk) begin
        if (pci_rst) begin
            req_to_arbiter <= '0;
            tog_q <= '0;
        end else begin
            req_to_arbiter <= ~req_n & ~(ctl_q[NUM_REQ-1:0] | local_q);
            tog_q <= tog_q ^ fire;
        end
    end

    for (genvar i = 0; i < NUM_REQ; i++) begin : g_event
        logic s1_q;
        logic s2_q;
        logic s3_q;
        // No reset here: the toggle survives the register-side resets, and clearing
        // these flops would make a stale toggle look like a fresh time-out.
        always_ff @(posedge clk) begin
            s1_q <= tog_q[i];
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
        assign event_clk[i] = s2_q ^ s3_q;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Independent count of idle clocks under one grant, kept for the checks only.
    logic [CNT_W-1:0] idle_run_q;

    always_ff @(posedge pci_clk) begin
        if (pci_rst || !enabled || grant_moved || !frame_n) begin
            idle_run_q <= '0;
        end else if (idle && idle_run_q != CNT_W'(TIMEOUT_CLOCKS)) begin
            idle_run_q <= idle_run_q + CNT_W'(1);
        end
    end

    idle_count_a: assert property (
        @(posedge pci_clk) disable iff (pci_rst)
        (|fire) |-> idle_run_q == CNT_W'(TIMEOUT_CLOCKS - 1))
        else $error("Time-out fired off the sixteenth idle clock");

    local_mask_a: assert property (
        @(posedge pci_clk) disable iff (pci_rst)
        ((|fire) && ctl_q[AUTO_IGNORE_BIT]) |-> ##2 (req_to_arbiter & $past(fire, 2)) == '0)
        else $error("Timed-out request still reached the arbiter");

    timeout_count_a: assert property (
        @(posedge pci_clk) disable iff (pci_rst)
        (|fire) |-> enabled && $past(state_q) == COUNT
                    && cnt_q == CNT_W'(TIMEOUT_CLOCKS - 1))
        else $error("Time-out fired without 16 idle clocks");

    timeout_off_a: assert property (
        @(posedge pci_clk) disable iff (pci_rst)
        !enabled |-> fire == '0)
        else $error("Time-out fired while disabled");

    auto_ignore_a: assert property (
        @(posedge clk) disable iff (reg_rst)
        ((|event_clk) && ignore_q[AUTO_IGNORE_BIT])
        |=> (ignore_q[NUM_REQ-1:0] & $past(event_clk)) == $past(event_clk))
        else $error("Timed-out request was not masked");

    ignored_req_a: assert property (
        @(posedge pci_clk) disable iff (pci_rst)
        ##1 (req_to_arbiter & $past(ctl_q[NUM_REQ-1:0])) == '0)
        else $error("Masked request reached the arbiter");

    reset_clear_a: assert property (
        @(posedge clk)
        reg_rst |=> ignore_q == REQ_IGNORE_RESET && status_q == '0)
        else $error("Registers not cleared by reset");

    status_set_a: assert property (
        @(posedge clk) disable iff (reg_rst)
        (|event_clk) |=> (status_q & $past(event_clk)) == $past(event_clk))
        else $error("Time-out status bit not set");

    reserved_zero_a: assert property (
        @(posedge clk) disable iff (reg_rst)
        (cfg_addr == TIMED_OUT_OFFSET) |=>
        cfg_rdata[RESERVED_MSB:RESERVED_LSB] == 2'b00)
        else $error("Reserved status bits read nonzero");

    status_hold_a: assert property (
        @(posedge clk) disable iff (reg_rst)
        !wr_status |=> (status_q & $past(status_q)) == $past(status_q))
        else $error("Status bit lost without a write");

    status_clear_a: assert property (
        @(posedge clk) disable iff (reg_rst)
        (wr_status && event_clk == '0)
        |=> (status_q & $past(cfg_wdata[NUM_REQ-1:0])) == '0)
        else $error("Write one did not clear status");

endmodule : arb_request_guard

`default_nettype wire

// [verification/bus_master_model.sv]
// Behavioural secondary-bus master that either answers its grant or stays silent.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input wire logic pci_clk,
    input wire logic pci_rst,
    input wire logic [5:0] grant,
    input wire logic answer,
    output logic frame_n,
    output logic irdy_n
);
    // A silent master leaves the pulled-up lines high, which is what trips the time-out.
    always_ff @(posedge pci_clk) begin
        if (pci_rst) begin
            frame_n <= 1'b1;
            irdy_n <= 1'b1;
        end else begin
            frame_n <= !(answer && grant != 6'h00);
            irdy_n <= frame_n;
        end
    end
endmodule : bus_master_model
`default_nettype wire

// [verification/secondary_arbiter_request_mask_timeout_test.sv]
// Self-checking bench for the arbiter request guard.
`timescale 1ns/1ps
`default_nettype none
module secondary_arbiter_request_mask_timeout_test;
    import arb_guard_pkg::*;
    typedef struct {logic [7:0] mask; logic [5:0] req_n; logic [7:0] exp;} row_s;
    logic clk, rst, link_reset, global_reset_input, cfg_wr, pci_clk, pci_rst, frame_n, irdy_n, answer;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, d;
    logic [5:0] req_n, grant, req_to_arbiter;
    int mismatches, total_checks, i;
    row_s rows[7] = '{'{8'h00, 6'h3f, 8'h00}, '{8'h00, 6'h00, 8'h3f}, '{8'h2a, 6'h00, 8'h15},
        '{8'h15, 6'h30, 8'h0a}, '{8'h3f, 6'h00, 8'h00}, '{8'h21, 6'h00, 8'h1e}, '{8'hc0, 6'h0c, 8'h33}};
    arb_request_guard uut (.clk, .rst, .link_reset, .global_reset_input, .cfg_addr, .cfg_wr, .cfg_wdata,
        .cfg_rdata, .pci_clk, .pci_rst, .req_n, .grant, .frame_n, .irdy_n, .req_to_arbiter);
    bus_master_model master (.pci_clk, .pci_rst, .grant, .answer, .frame_n, .irdy_n);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        pci_clk = 1'b0;
        #7;
        forever #80 pci_clk = ~pci_clk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        cfg_addr = a;
        cfg_wr = 1'b1;
        cfg_wdata = v;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        cfg_addr = a;
        @(negedge clk);
        v = cfg_rdata;
    endtask : rd
    task automatic pwait(input int n);
        repeat (n) @(negedge pci_clk);
    endtask : pwait
    // Status crosses domains, so it is polled with a bound rather than a fixed delay.
    task automatic poll(input logic [7:0] exp);
        d = 8'h00;
        for (int k = 0; k < 80 && d !== exp; k++) rd(8'hde, d);
        check("status", d, exp);
        if (d !== exp) results();
    endtask : poll
    task automatic pulse(ref logic r);
        @(negedge clk);
        r = 1'b1;
        @(negedge clk);
        r = 1'b0;
    endtask : pulse
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    initial begin
        #4000000;
        mismatches++;
        results();
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        {rst, pci_rst, link_reset, global_reset_input, cfg_wr, answer} = 6'h30;
        {cfg_addr, cfg_wdata, grant} = 22'h00_0000;
        req_n = 6'h3f;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        pci_rst = 1'b0;
        rd(8'hdd, d);
        check("mask reset", d, 8'h00);
        rd(8'hde, d);
        check("status reset", d, 8'h00);
        wr(8'hdf, 8'hff);
        rd(8'hdf, d);
        check("unmapped", d, 8'h00);
        rd(8'hdd, d);
        check("mask after unmapped", d, 8'h00);
        for (i = 0; i < 7; i++) begin
            wr(8'hdd, rows[i].mask);
            pwait(6);
            req_n = rows[i].req_n;
            pwait(2);
            check("requests", {2'b00, req_to_arbiter}, rows[i].exp);
            rd(8'hdd, d);
            check("mask", d, rows[i].mask);
        end
        $display("rows done");
        req_n = 6'h00;
        wr(8'hdd, 8'h00);
        pwait(6);
        grant = 6'h04;
        pwait(24);
        rd(8'hde, d);
        check("disabled", d, 8'h00);
        grant = 6'h00;
        wr(8'hdd, 8'h80);
        pwait(6);
        grant = 6'h04;
        pwait(13);
        rd(8'hde, d);
        check("early", d, 8'h00);
        poll(8'h04);
        check("no auto", {2'b00, req_to_arbiter}, 8'h3f);
        grant = 6'h00;
        wr(8'hde, 8'h00);
        rd(8'hde, d);
        check("write zero", d, 8'h04);
        wr(8'hde, 8'hff);
        rd(8'hde, d);
        check("write one", d, 8'h00);
        $display("timeout done");
        answer = 1'b1;
        grant = 6'h01;
        pwait(30);
        rd(8'hde, d);
        check("answered", d, 8'h00);
        grant = 6'h00;
        answer = 1'b0;
        wr(8'hdd, 8'hc0);
        pwait(6);
        grant = 6'h20;
        pwait(17);
        check("auto before", {2'b00, req_to_arbiter}, 8'h3f);
        pwait(1);
        check("auto at fire", {2'b00, req_to_arbiter}, 8'h1f);
        poll(8'h20);
        rd(8'hdd, d);
        check("auto mask", d, 8'he0);
        pwait(2);
        check("auto req", {2'b00, req_to_arbiter}, 8'h1f);
        grant = 6'h00;
        pulse(link_reset);
        rd(8'hdd, d);
        check("link mask", d, 8'h00);
        rd(8'hde, d);
        check("link status", d, 8'h00);
        pwait(6);
        check("link req", {2'b00, req_to_arbiter}, 8'h3f);
        wr(8'hdd, 8'h55);
        pulse(global_reset_input);
        rd(8'hdd, d);
        check("global mask", d, 8'h00);
        wr(8'hdd, 8'h55);
        pulse(rst);
        rd(8'hdd, d);
        check("power-on mask", d, 8'h00);
        $display("resets done");
        results();
    end
endmodule : secondary_arbiter_request_mask_timeout_test
`default_nettype wire
